// ==== verilog/tcb_regs.vh ====
`ifndef TCB_REGS_VH
`define TCB_REGS_VH

// Handshake mode encodings on the mode select input
`define TCB_MODE_OCTET 2'h0
`define TCB_MODE_CELL 2'h1
`define TCB_MODE_MPHY 2'h2

// Cell length in writes: 8-bit bus and 16-bit bus
`define TCB_CELL_LEN8 7'h35
`define TCB_CELL_LEN16 7'h1b

// Free entries needed for octet-level room
`define TCB_OCTET_ROOM 7'h04

// Queue geometry: data word plus first and last marks
`define TCB_Q_WIDTH 18
`define TCB_Q_DEPTH 64
`define TCB_Q_AW 6

// Width of the synchronised pin bundle
`define TCB_PIN_W 25

// Bit positions inside the synchronised pin bundle
`define TCB_PIN_CLK 24
`define TCB_PIN_WEN 23
`define TCB_PIN_SOC 22
`define TCB_PIN_PAR 21

`endif

// ==== verilog/tcb_queue.v ====
`timescale 1ns/1ns
// Synchronous queue; read data always come out of a register
module tcb_queue #(
  parameter WIDTH = 18,
  parameter DEPTH = 64,
  parameter AW = 6
) (
  // Clock, reset, enable
  input wire clk,
  input wire rstn,
  input wire ce,
  // Filling side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // Draining side
  output reg out_valid,
  input wire out_ready,
  output reg [WIDTH-1:0] out_data,
  // Entries held in storage, staging register excluded
  output wire [AW:0] level
);

  reg [WIDTH-1:0] mem [0:DEPTH-1]; // Storage array
  reg [AW-1:0] wr_ptr_q; // Next slot to fill
  reg [AW-1:0] rd_ptr_q; // Next slot to drain
  reg [AW:0] cnt_q; // Occupancy of the array
  wire push; // Write accepted this cycle
  wire pop; // Array entry moves to staging register

  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign push = in_valid & in_ready;
  // Refill the staging register whenever it is empty or being taken
  assign pop = (cnt_q != {(AW+1){1'b0}}) & (~out_valid | out_ready);
  assign level = cnt_q;

  //////////////////////////////////////////////////////////////////////
  // Array write; no reset needed on storage
  always @(posedge clk) begin
    if (ce && push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Pointers, occupancy and output register
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
      out_data <= {WIDTH{1'b0}};
    end else if (ce) begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        // Read data registered here, never straight from the array
        rd_ptr_q <= rd_ptr_q + 1'b1;
        out_data <= mem[rd_ptr_q];
        out_valid <= 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

endmodule

// ==== verilog/tcb_tx_port.v ====
// Contract
// RULE_01: Write enable low captures word each clock.
// RULE_02: Enable high: data bus ignored entirely.
// RULE_03: Start mark only with first cell word.
// RULE_04: Sender drives odd parity with each word.
// RULE_05: Device checks odd parity on every word.
// RULE_06: Octet mode: room high when four free.
// RULE_07: Cell mode: room high when cell fits.
// RULE_08: Multi-port: room floats until address matched.
// RULE_09: Bus sixteen bits, eight when narrow selected.
// RULE_10: Pulse cell sent once per departing cell.
// RULE_11: Address compared each edge with enable asserted.
// RULE_12: Reset asynchronous, outputs released, state defaulted.
// RULE_13: Link clock times capture and queue entry.
// RULE_14: Count words from start, 53 or 27.
`timescale 1ns/1ns
`include "tcb_regs.vh"
module tcb_tx_port (
  // Core clock, reset, enable
  input wire clk,
  input wire rstn,
  input wire ce,
  // Cell bus pins from the layer processor
  input wire tx_bus_clk,
  input wire tx_bus_write_enable_n,
  input wire tx_bus_cell_start,
  input wire tx_bus_odd_parity,
  input wire [15:0] tx_bus_word,
  input wire [4:0] tx_bus_port_select,
  // Cell room pin, three-state
  output reg tx_bus_cell_room,
  output reg tx_bus_cell_room_oe,
  // Configuration
  input wire [1:0] hs_mode,
  input wire bus_narrow,
  input wire [4:0] port_address,
  // Status pulses
  output reg parity_error_pulse,
  output reg overflow_pulse,
  output reg cell_error_pulse,
  // Cell words toward the downstream processors
  output wire [15:0] cell_word,
  output wire cell_word_first,
  output wire cell_word_last,
  output wire cell_word_valid,
  input wire cell_word_ready,
  output reg cell_sent_pulse
);

  //////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  wire [`TCB_PIN_W-1:0] pins; // Raw pin bundle
  reg [`TCB_PIN_W-1:0] s1_q; // First stage, read only by s2
  reg [`TCB_PIN_W-1:0] s2_q; // Second stage
  reg [`TCB_PIN_W-1:0] s3_q; // Value one sample before s2

  assign pins = {tx_bus_clk, tx_bus_write_enable_n, tx_bus_cell_start,
                 tx_bus_odd_parity, tx_bus_port_select, tx_bus_word};

  genvar gi;
  generate
    for (gi = 0; gi < `TCB_PIN_W; gi = gi + 1) begin : g_sync
      // Three flops per pin; first one feeds only the second
      always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          s1_q[gi] <= 1'b0;
          s2_q[gi] <= 1'b0;
          s3_q[gi] <= 1'b0;
        end else if (ce) begin
          s1_q[gi] <= pins[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////
  // Link edge and sampled pin values
  wire link_rise; // Rising link clock seen this cycle
  wire wen_n_s; // Write enable, active low
  wire soc_s; // Start of cell mark
  wire par_s; // Parity bit from the bus
  wire [4:0] addr_s; // Port select bus
  wire [15:0] data_raw; // Data bus as sampled
  wire [15:0] data_s; // Data bus trimmed to active width
  wire [6:0] cell_len; // Writes per cell for the bus width
  wire par_ok; // Odd parity holds over data plus bit
  reg sel_q; // Port address matched at last link edge
  wire wr_req; // Write addressed to this port

  // RULE_13
  assign link_rise = s2_q[`TCB_PIN_CLK] & ~s3_q[`TCB_PIN_CLK];
  // Pins taken from s3: sampled just before the edge, so a 1 ns hold
  // after the edge cannot leak the next word into this capture
  assign wen_n_s = s3_q[`TCB_PIN_WEN];
  assign soc_s = s3_q[`TCB_PIN_SOC];
  assign par_s = s3_q[`TCB_PIN_PAR];
  assign addr_s = s3_q[20:16];
  assign data_raw = s3_q[15:0];
  // Narrow bus: upper byte is dead and stored as zero
  assign data_s = bus_narrow ? {8'h00, data_raw[7:0]} : data_raw; // RULE_09
  assign cell_len = bus_narrow ? `TCB_CELL_LEN8 : `TCB_CELL_LEN16; // RULE_14
  assign par_ok = ^{par_s, data_s}; // RULE_05
  // Multi-port mode only takes writes while this port is selected
  assign wr_req = ~wen_n_s &
                  ((hs_mode != `TCB_MODE_MPHY) | sel_q); // RULE_01 RULE_02

  //////////////////////////////////////////////////////////////////////
  // Queue and its staging
  reg [6:0] cnt_q; // Writes taken in the current cell
  reg in_cell_q; // A cell is open
  reg wr_valid_q; // Word waiting to enter the queue
  reg [`TCB_Q_WIDTH-1:0] wr_data_q; // Word, first and last marks
  wire q_in_ready; // Queue has a free slot
  wire [`TCB_Q_AW:0] q_level; // Queue occupancy
  wire [`TCB_Q_WIDTH-1:0] q_out; // Queue head
  wire [7:0] free_slots; // Slots left after the pending word
  wire [6:0] cnt_inc; // Write count after this word

  assign cnt_inc = cnt_q + 7'h01;
  assign free_slots = 8'h40 - {1'b0, q_level} - {7'h00, wr_valid_q};

  tcb_queue #(
    .WIDTH(`TCB_Q_WIDTH),
    .DEPTH(`TCB_Q_DEPTH),
    .AW(`TCB_Q_AW)
  ) u_tx_cell_queue (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .in_valid(wr_valid_q),
    .in_ready(q_in_ready),
    .in_data(wr_data_q),
    .out_valid(cell_word_valid),
    .out_ready(cell_word_ready),
    .out_data(q_out),
    .level(q_level)
  );

  assign cell_word = q_out[15:0];
  assign cell_word_first = q_out[16];
  assign cell_word_last = q_out[17];

  //////////////////////////////////////////////////////////////////////
  // Capture, cell counting and parity checking on link edges
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sel_q <= 1'b0;
      cnt_q <= 7'h00;
      in_cell_q <= 1'b0;
      wr_valid_q <= 1'b0;
      wr_data_q <= {`TCB_Q_WIDTH{1'b0}};
      parity_error_pulse <= 1'b0;
      cell_error_pulse <= 1'b0;
      overflow_pulse <= 1'b0;
    end else if (ce) begin
      parity_error_pulse <= 1'b0;
      cell_error_pulse <= 1'b0;
      // Pending word leaves after one cycle; a full queue drops it
      overflow_pulse <= wr_valid_q & ~q_in_ready;
      wr_valid_q <= 1'b0;
      if (link_rise) begin
        // Match needs address and asserted enable together
        sel_q <= (addr_s == port_address) & ~wen_n_s; // RULE_11
        if (wr_req) begin
          // Parity is flagged but the word is kept
          parity_error_pulse <= ~par_ok; // RULE_05
          if (soc_s) begin
            // New cell restarts the count, even mid-cell
            cnt_q <= 7'h01; // RULE_14
            in_cell_q <= 1'b1;
            cell_error_pulse <= in_cell_q;
            wr_valid_q <= 1'b1; // RULE_01
            wr_data_q <= {1'b0, 1'b1, data_s};
          end else if (in_cell_q) begin
            cnt_q <= cnt_inc; // RULE_14
            in_cell_q <= (cnt_inc != cell_len);
            wr_valid_q <= 1'b1; // RULE_01
            wr_data_q <= {(cnt_inc == cell_len), 1'b0, data_s};
          end else begin
            // Word outside any cell: discarded and flagged
            cell_error_pulse <= 1'b1;
          end
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Cell room flag and its drive enable
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      // Pin floats during and right after reset
      tx_bus_cell_room <= 1'b0; // RULE_12
      tx_bus_cell_room_oe <= 1'b0; // RULE_12
    end else if (ce) begin
      case (hs_mode)
        `TCB_MODE_OCTET: begin
          tx_bus_cell_room <= (free_slots >= {1'b0, `TCB_OCTET_ROOM}); // RULE_06
          tx_bus_cell_room_oe <= 1'b1;
        end
        `TCB_MODE_CELL: begin
          tx_bus_cell_room <= (free_slots >= {1'b0, cell_len}); // RULE_07
          tx_bus_cell_room_oe <= 1'b1;
        end
        `TCB_MODE_MPHY: begin
          // Cell-level rule, driven only once the address matched
          tx_bus_cell_room <= (free_slots >= {1'b0, cell_len}); // RULE_08
          tx_bus_cell_room_oe <= sel_q; // RULE_08
        end
        default: begin
          // Unused mode code: keep the pin released
          tx_bus_cell_room <= 1'b0;
          tx_bus_cell_room_oe <= 1'b0;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // One pulse per complete cell handed downstream
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cell_sent_pulse <= 1'b0;
    end else if (ce) begin
      cell_sent_pulse <= cell_word_valid & cell_word_ready &
                         cell_word_last; // RULE_10
    end
  end

endmodule

// ==== dv/tcb_tx_port_checker.sv ====
`timescale 1ns/1ns
module tcb_tx_port_checker (
  // Clock, reset, pins, config
  input logic clk,
  input logic rstn,
  input logic tx_bus_write_enable_n,
  input logic [4:0] tx_bus_port_select,
  input logic [4:0] port_address,
  input logic [1:0] hs_mode,
  input logic tx_bus_cell_room_oe,
  // Pulses and queue head
  input logic parity_error_pulse,
  input logic cell_error_pulse,
  input logic overflow_pulse,
  input logic [15:0] cell_word,
  input logic cell_word_valid,
  input logic cell_word_ready,
  input logic cell_word_last,
  input logic cell_sent_pulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Pin is still released at the first edge after reset
  a_reset_pin_off: assert property (
    $rose(rstn) |-> !tx_bus_cell_room_oe) else $error("oe at reset exit");
  a_octet_drives: assert property (
    $past(rstn) && hs_mode == 2'h0 && $past(hs_mode) == 2'h0
    |-> tx_bus_cell_room_oe) else $error("octet pin not driven");
  a_cell_drives: assert property (
    $past(rstn) && hs_mode == 2'h1 && $past(hs_mode) == 2'h1
    |-> tx_bus_cell_room_oe) else $error("cell pin not driven");
  // Sync chain, sel_q and the oe flop put the matching address five edges back; held pins still show it three back
  a_select_first: assert property (
    $rose(tx_bus_cell_room_oe) && hs_mode == 2'h2
    |-> $past(tx_bus_port_select, 3) == port_address)
    else $error("pin driven without match");
  a_idle_no_write: assert property (
    tx_bus_write_enable_n [*6] |-> !parity_error_pulse
    && !cell_error_pulse && !overflow_pulse) else $error("idle write");
  a_sent_after_last: assert property (
    cell_word_valid && cell_word_ready && cell_word_last
    |=> cell_sent_pulse ##1 !cell_sent_pulse) else $error("no sent pulse");
  a_sent_has_cause: assert property (
    cell_sent_pulse |-> $past(cell_word_last) && $past(cell_word_valid)
    && $past(cell_word_ready)) else $error("stray sent pulse");
  a_head_holds: assert property (
    cell_word_valid && !cell_word_ready
    |=> cell_word_valid && $stable(cell_word)) else $error("head lost");
  a_parity_single: assert property (
    parity_error_pulse |=> !parity_error_pulse) else $error("long pulse");
endmodule
bind tcb_tx_port tcb_tx_port_checker u_chk (.clk, .rstn,
  .tx_bus_write_enable_n, .tx_bus_port_select, .port_address, .hs_mode,
  .tx_bus_cell_room_oe, .parity_error_pulse, .cell_error_pulse,
  .overflow_pulse, .cell_word, .cell_word_valid, .cell_word_ready,
  .cell_word_last, .cell_sent_pulse);

// ==== dv/tcb_layer_model.sv ====
`timescale 1ns/1ns
// Layer processor: one write per link clock period of 8 clk
module tcb_layer_model (
  // Clock and bus width
  input logic clk,
  input logic bus_narrow,
  // Bus pins
  output logic tx_bus_clk,
  output logic tx_bus_write_enable_n,
  output logic tx_bus_cell_start,
  output logic tx_bus_odd_parity,
  output logic [15:0] tx_bus_word,
  output logic [4:0] tx_bus_port_select
);
  initial begin
    tx_bus_clk = 1'b0;
    tx_bus_write_enable_n = 1'b1;
    {tx_bus_cell_start, tx_bus_odd_parity} = 2'h0;
    {tx_bus_word, tx_bus_port_select} = 21'h00_0000;
  end
  // Pins held four clk before the link rise and three after it; the
  // link clock idles high between writes, so back to back it is 8 clk
  task put(input logic [15:0] d, input logic s, b, input logic [4:0] a);
    @(posedge clk);
    tx_bus_clk <= 1'b0;
    tx_bus_write_enable_n <= 1'b0;
    tx_bus_cell_start <= s;
    tx_bus_word <= d;
    tx_bus_port_select <= a;
    tx_bus_odd_parity <= ~^(bus_narrow ? {8'h00, d[7:0]} : d) ^ b;
    repeat (4) @(posedge clk);
    tx_bus_clk <= 1'b1;
    repeat (3) @(posedge clk);
    // Released lines show the inverse so stale data cannot pass
    tx_bus_write_enable_n <= 1'b1;
    tx_bus_cell_start <= 1'b0;
    tx_bus_word <= ~d;
    tx_bus_odd_parity <= ~tx_bus_odd_parity;
  endtask
endmodule

// ==== dv/tcb_tx_port_tb.sv ====
`timescale 1ns/1ns
`include "tcb_regs.vh"
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin n_errors++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, s); end end
module tcb_tx_port_tb;
  // Design inputs owned by the bench
  logic clk = 0, rstn = 0, ce = 1, bus_narrow = 0, cell_word_ready = 0;
  logic [1:0] hs_mode = `TCB_MODE_CELL;
  logic [4:0] port_address = 5'h00;
  wire tx_bus_clk, tx_bus_write_enable_n, tx_bus_cell_start;
  wire tx_bus_odd_parity, tx_bus_cell_room, tx_bus_cell_room_oe;
  wire parity_error_pulse, overflow_pulse, cell_error_pulse, cell_sent_pulse;
  wire cell_word_first, cell_word_last, cell_word_valid;
  wire [15:0] tx_bus_word, cell_word;
  wire [4:0] tx_bus_port_select;
  // Counters, expected queue, random state
  int n_errors = 0, n_checks = 0, ns = 0, np = 0, nc = 0, no = 0;
  int ecell = 0, bad = -1;
  logic [31:0] seed = 32'h0000_51a5, rs = 32'h0000_51a5;
  logic stall = 0;
  logic [4:0] a;
  logic [17:0] w, exq[$];
  tcb_tx_port dut (.clk, .rstn, .ce, .tx_bus_clk, .tx_bus_write_enable_n,
    .tx_bus_cell_start, .tx_bus_odd_parity, .tx_bus_word, .tx_bus_port_select,
    .tx_bus_cell_room, .tx_bus_cell_room_oe, .hs_mode, .bus_narrow,
    .port_address, .parity_error_pulse, .overflow_pulse, .cell_error_pulse,
    .cell_word, .cell_word_first, .cell_word_last, .cell_word_valid,
    .cell_word_ready, .cell_sent_pulse);
  tcb_layer_model m (.clk, .bus_narrow, .tx_bus_clk, .tx_bus_write_enable_n,
    .tx_bus_cell_start, .tx_bus_odd_parity, .tx_bus_word, .tx_bus_port_select);
  always #25 clk = ~clk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  // Count pulses, compare each word taken, stall the far side at random
  always @(posedge clk) begin
    ns += cell_sent_pulse;
    np += parity_error_pulse;
    nc += cell_error_pulse;
    no += overflow_pulse;
    if (cell_word_valid && cell_word_ready) begin
      w = exq.pop_front();
      `CHK("word", w, {cell_word_last, cell_word_first, cell_word})
    end
    rs <= xs(rs);
    cell_word_ready <= !stall && rs[1:0] != 2'b00;
  end
  task settle;
    repeat (12) @(posedge clk);
  endtask
  task drain;
    stall <= 1'b0;
    repeat (3000) if (exq.size() != 0) @(posedge clk);
    `CHK("left", 0, exq.size())
    settle;
  endtask
  // Words i0.. of one cell; only the first k of them come out
  task wds(input int i0, n, k, input logic [4:0] ad);
    int len;
    len = bus_narrow ? `TCB_CELL_LEN8 : `TCB_CELL_LEN16;
    for (int i = i0; i < i0 + n; i++) begin
      seed = xs(seed);
      if (i - i0 < k) begin
        exq.push_back({i == len - 1, i == 0,
          bus_narrow ? {8'h00, seed[7:0]} : seed[15:0]});
        ecell += (i == len - 1);
      end
      m.put(seed[15:0], i == 0, i == bad, ad);
    end
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    seed = xs(seed);
    a = seed[4:0];
    bad = 9;
    wds(0, 27, 27, a);
    bad = -1;
    drain;
    `CHK("parity", 1, np)
    // A word with no open cell is dropped
    wds(4, 1, 0, a);
    settle;
    `CHK("stray", 1, nc)
    bus_narrow <= 1'b1;
    @(posedge clk);
    wds(0, 53, 53, a);
    drain;
    bus_narrow <= 1'b0;
    `CHK("sent8", ecell, ns)
    // Unused mode code releases a driven pin
    hs_mode <= 2'h3;
    settle;
    `CHK("released", 1'b0, tx_bus_cell_room_oe)
    hs_mode <= `TCB_MODE_CELL;
    // Stalled far side: head register plus 64 stored words
    stall <= 1'b1;
    wds(0, 27, 27, a);
    settle;
    `CHK("room", 1'b1, tx_bus_cell_room)
    wds(0, 27, 27, a);
    settle;
    `CHK("room", 1'b0, tx_bus_cell_room)
    hs_mode <= `TCB_MODE_OCTET;
    settle;
    `CHK("octet", 1'b1, tx_bus_cell_room)
    wds(0, 8, 8, a);
    settle;
    `CHK("octet", 1'b0, tx_bus_cell_room)
    wds(8, 5, 3, a);
    settle;
    `CHK("overflow", 2, no)
    drain;
    // New start leaves the open cell short
    hs_mode <= `TCB_MODE_CELL;
    wds(0, 27, 27, a);
    drain;
    `CHK("short", 2, nc)
    // Multi-port: select word, cell, then a last word for another port
    port_address <= a;
    hs_mode <= `TCB_MODE_MPHY;
    settle;
    `CHK("float", 1'b0, tx_bus_cell_room_oe)
    wds(0, 1, 0, a);
    settle;
    `CHK("drive", 1'b1, tx_bus_cell_room_oe)
    `CHK("mroom", 1'b1, tx_bus_cell_room)
    wds(0, 26, 26, a);
    wds(26, 1, 1, a ^ 5'h01);
    drain;
    `CHK("unsel", 1'b0, tx_bus_cell_room_oe)
    `CHK("sent", ecell, ns)
    hs_mode <= `TCB_MODE_CELL;
    settle;
    // Frozen clock enable must miss a whole stray write
    ce <= 1'b0;
    wds(4, 1, 0, a);
    ce <= 1'b1;
    settle;
    `CHK("frozen", 2, nc)
    rstn <= 1'b0;
    #1;
    `CHK("rst_oe", 1'b0, tx_bus_cell_room_oe)
    `CHK("rst_valid", 1'b0, cell_word_valid)
    print_verdict;
  end
  // Whole run needs about 2000 clk
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    print_verdict;
  end
endmodule
